//--- common/scnd_pkg.sv
// shared constants, types and helpers for the serial config nibble decoder
package scnd_pkg;

  // clock and internal oscillator
  localparam real CLK_PERIOD_NS = 5.0;
  localparam real OSC_PERIOD_NS = 1000.0;
  localparam int unsigned OSC_DIV_CYCLES = int'(OSC_PERIOD_NS / CLK_PERIOD_NS);
  localparam int unsigned OSC_TICKS_PER_MS = 1000;

  // dac refresh intervals in ms
  localparam real REFRESH_MS_0 = 4.096;
  localparam real REFRESH_MS_1 = 16.384;
  localparam real REFRESH_MS_2 = 65.536;
  localparam real REFRESH_MS_3 = 131.072;

  // digital-mode window per repetition, ms; codes above 9 use the last entry
  localparam int unsigned WIN_MS [11] = '{1, 2, 3, 4, 5, 8, 10, 15, 20, 25, 30};
  localparam int unsigned WIN_LAST_CODE = 9;

  // register byte offsets
  localparam logic [7:0] OFF_NIBBLE = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h04;
  localparam logic [7:0] OFF_BIT_PERIOD = 8'h08;
  localparam logic [7:0] OFF_SESSION = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_HOLD = 8'h14;
  localparam logic [7:0] OFF_ADDR = 8'h18;
  localparam logic [7:0] OFF_CMD = 8'h1c;
  localparam logic [7:0] OFF_RESP = 8'h20;

  // session register bits
  localparam int unsigned SES_CTRL_WORD_BIT = 0;
  localparam int unsigned SES_RESTART_BIT = 1;

  // register-select codes
  localparam logic [3:0] SEL_HOLD0 = 4'h0;
  localparam logic [3:0] SEL_HOLD1 = 4'h1;
  localparam logic [3:0] SEL_HOLD2 = 4'h2;
  localparam logic [3:0] SEL_HOLD3 = 4'h3;
  localparam logic [3:0] SEL_CALIB_ADDR = 4'h6;
  localparam logic [3:0] SEL_FLASH_MID = 4'h7;
  localparam logic [3:0] SEL_POINTER = 4'h8;
  localparam logic [3:0] SEL_COMMAND = 4'h9;
  localparam logic [3:0] SEL_TIMEOUT = 4'ha;
  localparam logic [3:0] SEL_LOC_LO = 4'hb;
  localparam logic [3:0] SEL_LOC_HI = 4'hc;
  localparam logic [3:0] SEL_BURST = 4'hd;

  // commands and read pointer values
  localparam logic [3:0] load_calib_reg_cmd = 4'h0;
  localparam logic [3:0] read_iface_reg_cmd = 4'h5;
  localparam logic [3:0] PTR_TEST = 4'hf;
  localparam logic [7:0] TEST_BYTE = 8'hca;

  // response and session values
  localparam logic [2:0] REPEAT_DIRECT = 3'h7;
  localparam logic [15:0] BIT_PERIOD_RST = 16'h00c8;
  localparam logic [6:0] BITS_PER_BYTE = 7'h08;

  typedef struct packed {
    logic [2:0] control_word_repeat_count;
    logic [3:0] digital_window_time_sel;
    logic [1:0] read_response_delay_sel;
    logic [1:0] dac_refresh_interval_sel;
  } scnd_cfg_t;

  localparam scnd_cfg_t CFG_RST = '{3'h7, 4'hf, 2'h0, 2'h0};

  function automatic logic [17:0] scnd_win_ticks(input logic [3:0] sel);
    int unsigned idx;
    idx = (int'(sel) > WIN_LAST_CODE) ? WIN_LAST_CODE + 1 : int'(sel);
    return 18'(WIN_MS[idx] * OSC_TICKS_PER_MS);
  endfunction

  function automatic logic [17:0] scnd_refresh_ticks(input logic [1:0] sel);
    real ms;
    case (sel)
      2'h0: ms = REFRESH_MS_0;
      2'h1: ms = REFRESH_MS_1;
      2'h2: ms = REFRESH_MS_2;
      default: ms = REFRESH_MS_3;
    endcase
    return 18'(int'(ms * real'(OSC_TICKS_PER_MS)));
  endfunction

endpackage

//--- hw/scnd_decoder.sv
// serial config nibble decoder with axi4-lite register access
//
// Contract
// - dac refresh pulse every 4.096/16.384/65.536/131.072 ms by two-bit field.
// - read response delay is 1, 2, 4 or 8 byte times of eight bit periods.
// - delay before and after the sent byte; programmer keeps off the line.
// - digital window per repetition 1..25 ms by code, 30 ms above 1001.
// - window times count internal oscillator ticks, nominally 1 MHz.
// - window field resets to all ones, the 30 ms setting.
// - repetition field sets control words needed: 000/001 one, else its value.
// - repetition code 111 enters digital mode directly at power-up.
// - selects 0000..0011 store nibble into hold register bits 3:0..15:12.
// - select 0110 writes calibration address, also flash address bits 3:0.
// - select 0111 writes flash address bits 7:4.
// - select 1000 writes read pointer; low three bits are flash bits 10:8.
// - select 1001 writes the command register and runs the command.
// - select 1010 writes the analog readout timeout field.
// - select 1011 writes analog location bits 3:0.
// - select 1100 copies data bit 0 into analog location bit 4.
// - select 1101 copies data bit 0 into the burst enable bit.
// - command 0000 loads addressed calibration register with hold register.
// - pointer 1111 with read command returns test byte 11001010.
`timescale 1ns/1ps
module scnd_decoder
  import scnd_pkg::*;
#(
  parameter int unsigned OSC_DIV = OSC_DIV_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic digital_mode,
  output logic calib_load,
  output logic [3:0] calib_load_addr,
  output logic [15:0] calib_load_data,
  output logic dac_refresh,
  output logic dio_out,
  output logic dio_oe,
  output logic line_quiet,
  output logic burst_enable,
  output logic [4:0] analog_location,
  output logic [3:0] analog_timeout,
  output logic [10:0] flash_address
);

  typedef enum logic [3:0] {
    RS_IDLE = 4'b0001,
    RS_PRE = 4'b0010,
    RS_SEND = 4'b0100,
    RS_POST = 4'b1000
  } scnd_resp_t;

  logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg, rdata_reg, rdata_next;
  logic [3:0] w_strb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic wr_do, wr_hit;
  logic [31:0] wmask;
  scnd_cfg_t cfg_reg;
  logic [15:0] bit_period_reg;
  logic [15:0] data_hold_reg;
  logic [3:0] calib_reg_addr, flash_mid_reg, iface_read_pointer, internal_command_reg;
  logic [3:0] analog_read_timeout;
  logic [4:0] analog_location_sel;
  logic burst_enable_bit;
  logic nib_we, ctrl_word, restart;
  logic [3:0] iface_reg_select, iface_nibble_data;
  logic [15:0] osc_cnt_reg;
  logic osc_tick;
  logic [17:0] refresh_cnt_reg, win_cnt_reg;
  logic dac_refresh_reg, digital_reg, win_active_reg, start_reg;
  logic [2:0] rep_cnt_reg, rep_need;
  logic calib_load_reg;
  logic [3:0] calib_addr_out_reg;
  logic [15:0] calib_data_out_reg;
  scnd_resp_t resp_state_reg;
  logic [15:0] bp_cnt_reg;
  logic [6:0] bits_left_reg, delay_bits;
  logic [7:0] tx_byte_reg, sel_byte;
  logic bit_tick, read_start;

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: address and data may arrive in either order

  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign wr_do = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}},
                  {8{w_strb_reg[0]}}};
  assign wr_hit = (aw_addr_reg == OFF_NIBBLE) || (aw_addr_reg == OFF_CONFIG) ||
                  (aw_addr_reg == OFF_BIT_PERIOD) || (aw_addr_reg == OFF_SESSION);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_reg) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_do) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? 2'h0 : 2'h2;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    rdata_next = 32'h00000000;
    case (s_axi_araddr)
      OFF_CONFIG: rdata_next = {21'h000000, cfg_reg};
      OFF_BIT_PERIOD: rdata_next = {16'h0000, bit_period_reg};
      OFF_STATUS: rdata_next = {26'h0000000, rep_cnt_reg, resp_state_reg != RS_IDLE,
                                win_active_reg, digital_reg};
      OFF_HOLD: rdata_next = {16'h0000, data_hold_reg};
      OFF_ADDR: rdata_next = {17'h00000, iface_read_pointer, flash_address};
      OFF_CMD: rdata_next = {18'h00000, burst_enable_bit, analog_location_sel,
                             analog_read_timeout, internal_command_reg};
      OFF_RESP: rdata_next = {24'h000000, tx_byte_reg};
      default: rdata_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= 2'h0;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rdata_next;
      rresp_reg <= (s_axi_araddr == OFF_NIBBLE || s_axi_araddr == OFF_SESSION ||
                    s_axi_araddr[7:6] != 2'h0 || s_axi_araddr > OFF_RESP) ? 2'h2 : 2'h0;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration and session strobes

  assign nib_we = wr_do && aw_addr_reg == OFF_NIBBLE && w_strb_reg[0] && digital_reg;
  assign iface_reg_select = w_data_reg[7:4];
  assign iface_nibble_data = w_data_reg[3:0];
  assign ctrl_word = wr_do && aw_addr_reg == OFF_SESSION && w_strb_reg[0] &&
                     w_data_reg[SES_CTRL_WORD_BIT];
  assign restart = wr_do && aw_addr_reg == OFF_SESSION && w_strb_reg[0] &&
                   w_data_reg[SES_RESTART_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= CFG_RST;
      bit_period_reg <= BIT_PERIOD_RST;
    end else if (wr_do && aw_addr_reg == OFF_CONFIG) begin
      cfg_reg <= scnd_cfg_t'(11'((32'(cfg_reg) & ~wmask) | (w_data_reg & wmask)));
    end else if (wr_do && aw_addr_reg == OFF_BIT_PERIOD) begin
      bit_period_reg <= (bit_period_reg & ~wmask[15:0]) | (w_data_reg[15:0] & wmask[15:0]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // oscillator tick and dac refresh

  assign osc_tick = osc_cnt_reg == 16'(OSC_DIV - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn || osc_tick) begin
      osc_cnt_reg <= 16'h0000;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refresh_cnt_reg <= 18'h00000;
      dac_refresh_reg <= 1'b0;
    end else begin
      dac_refresh_reg <= 1'b0;
      if (osc_tick) begin
        if (refresh_cnt_reg >= scnd_refresh_ticks(cfg_reg.dac_refresh_interval_sel) - 18'h1) begin
          refresh_cnt_reg <= 18'h00000;
          dac_refresh_reg <= 1'b1;
        end else begin
          refresh_cnt_reg <= refresh_cnt_reg + 18'h00001;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // power-up session: window per repetition, then digital or analog mode

  assign rep_need = (cfg_reg.control_word_repeat_count <= 3'h1) ? 3'h1 :
                    cfg_reg.control_word_repeat_count;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_reg <= 1'b1;
      digital_reg <= 1'b0;
      win_active_reg <= 1'b0;
      win_cnt_reg <= 18'h00000;
      rep_cnt_reg <= 3'h0;
    end else if (start_reg || restart) begin
      start_reg <= 1'b0;
      rep_cnt_reg <= 3'h0;
      win_cnt_reg <= 18'h00000;
      digital_reg <= cfg_reg.control_word_repeat_count == REPEAT_DIRECT;
      win_active_reg <= cfg_reg.control_word_repeat_count != REPEAT_DIRECT;
    end else if (win_active_reg) begin
      if (ctrl_word) begin
        rep_cnt_reg <= rep_cnt_reg + 3'h1;
        win_cnt_reg <= 18'h00000;
        if (rep_cnt_reg + 3'h1 >= rep_need) begin
          digital_reg <= 1'b1;
          win_active_reg <= 1'b0;
        end
      end else if (osc_tick) begin
        if (win_cnt_reg >= scnd_win_ticks(cfg_reg.digital_window_time_sel) - 18'h1) begin
          win_active_reg <= 1'b0;
        end else begin
          win_cnt_reg <= win_cnt_reg + 18'h00001;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // nibble decode into the interface fields; reserved selects fall through

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_hold_reg <= 16'h0000;
      calib_reg_addr <= 4'h0;
      flash_mid_reg <= 4'h0;
      iface_read_pointer <= 4'h0;
      internal_command_reg <= 4'h0;
      analog_read_timeout <= 4'h0;
      analog_location_sel <= 5'h00;
      burst_enable_bit <= 1'b0;
    end else if (nib_we) begin
      case (iface_reg_select)
        SEL_HOLD0: data_hold_reg[3:0] <= iface_nibble_data;
        SEL_HOLD1: data_hold_reg[7:4] <= iface_nibble_data;
        SEL_HOLD2: data_hold_reg[11:8] <= iface_nibble_data;
        SEL_HOLD3: data_hold_reg[15:12] <= iface_nibble_data;
        SEL_CALIB_ADDR: calib_reg_addr <= iface_nibble_data;
        SEL_FLASH_MID: flash_mid_reg <= iface_nibble_data;
        SEL_POINTER: iface_read_pointer <= iface_nibble_data;
        SEL_COMMAND: internal_command_reg <= iface_nibble_data;
        SEL_TIMEOUT: analog_read_timeout <= iface_nibble_data;
        SEL_LOC_LO: analog_location_sel[3:0] <= iface_nibble_data;
        SEL_LOC_HI: analog_location_sel[4] <= iface_nibble_data[0];
        SEL_BURST: burst_enable_bit <= iface_nibble_data[0];
        default: data_hold_reg <= data_hold_reg;
      endcase
    end
  end

  assign flash_address = {iface_read_pointer[2:0], flash_mid_reg, calib_reg_addr};
  assign burst_enable = burst_enable_bit;
  assign analog_location = analog_location_sel;
  assign analog_timeout = analog_read_timeout;
  assign digital_mode = digital_reg;

  //////////////////////////////////////////////////////////////////////////////
  // command execution

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      calib_load_reg <= 1'b0;
      calib_addr_out_reg <= 4'h0;
      calib_data_out_reg <= 16'h0000;
    end else begin
      calib_load_reg <= nib_we && iface_reg_select == SEL_COMMAND &&
                        iface_nibble_data == load_calib_reg_cmd;
      if (nib_we && iface_reg_select == SEL_COMMAND &&
          iface_nibble_data == load_calib_reg_cmd) begin
        calib_addr_out_reg <= calib_reg_addr;
        calib_data_out_reg <= data_hold_reg;
      end
    end
  end

  assign calib_load = calib_load_reg;
  assign calib_load_addr = calib_addr_out_reg;
  assign calib_load_data = calib_data_out_reg;

  //////////////////////////////////////////////////////////////////////////////
  // read response: quiet delay, byte lsb first, quiet delay

  always_comb begin
    case (iface_read_pointer)
      4'h0: sel_byte = data_hold_reg[7:0];
      4'h1: sel_byte = data_hold_reg[15:8];
      4'h2: sel_byte = {1'b0, iface_read_pointer[2:0], calib_reg_addr};
      4'h3: sel_byte = {internal_command_reg, iface_read_pointer};
      4'h4: sel_byte = {4'h0, analog_read_timeout};
      4'h5: sel_byte = {flash_mid_reg, calib_reg_addr};
      4'h9: sel_byte = {2'h0, burst_enable_bit, analog_location_sel};
      PTR_TEST: sel_byte = TEST_BYTE;
      default: sel_byte = 8'h00;
    endcase
  end

  // a read command that lands while a response runs is dropped rather than queued
  assign read_start = nib_we && iface_reg_select == SEL_COMMAND &&
                      iface_nibble_data == read_iface_reg_cmd && resp_state_reg == RS_IDLE;
  assign delay_bits = BITS_PER_BYTE << cfg_reg.read_response_delay_sel;
  assign bit_tick = bp_cnt_reg >= bit_period_reg - 16'h0001;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resp_state_reg <= RS_IDLE;
      bp_cnt_reg <= 16'h0000;
      bits_left_reg <= 7'h00;
      tx_byte_reg <= 8'h00;
    end else begin
      bp_cnt_reg <= (bit_tick || resp_state_reg == RS_IDLE) ? 16'h0000 : bp_cnt_reg + 16'h0001;
      case (resp_state_reg)
        RS_IDLE: if (read_start) begin
          resp_state_reg <= RS_PRE;
          bits_left_reg <= delay_bits;
          tx_byte_reg <= sel_byte;
        end
        RS_PRE: if (bit_tick) begin
          bits_left_reg <= (bits_left_reg == 7'h01) ? BITS_PER_BYTE : bits_left_reg - 7'h01;
          if (bits_left_reg == 7'h01) resp_state_reg <= RS_SEND;
        end
        RS_SEND: if (bit_tick) begin
          bits_left_reg <= (bits_left_reg == 7'h01) ? delay_bits : bits_left_reg - 7'h01;
          if (bits_left_reg == 7'h01) resp_state_reg <= RS_POST;
        end
        RS_POST: if (bit_tick) begin
          bits_left_reg <= bits_left_reg - 7'h01;
          if (bits_left_reg == 7'h01) resp_state_reg <= RS_IDLE;
        end
        default: resp_state_reg <= RS_IDLE;
      endcase
    end
  end

  assign dio_oe = resp_state_reg == RS_SEND;
  assign dio_out = dio_oe ? tx_byte_reg[3'(BITS_PER_BYTE - bits_left_reg)] : 1'b0;
  assign line_quiet = resp_state_reg != RS_IDLE;
  assign dac_refresh = dac_refresh_reg;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  a_hold_low_nibble: assert property (@(posedge aclk) disable iff (!aresetn)
    nib_we && iface_reg_select == SEL_HOLD0 |=> data_hold_reg[3:0] == $past(iface_nibble_data))
    else $error("hold nibble 0 not stored");
  a_reserved_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
    nib_we && (iface_reg_select == 4'h4 || iface_reg_select == 4'h5 ||
    iface_reg_select >= 4'he) |=>
    $stable(data_hold_reg) && $stable(flash_address) && $stable(analog_location_sel))
    else $error("reserved select changed a field");
  a_loc_high_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    nib_we && iface_reg_select == SEL_LOC_HI |=>
    analog_location_sel == {$past(iface_nibble_data[0]), $past(analog_location_sel[3:0])})
    else $error("location bit 4 wrong");
  a_burst_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    nib_we && iface_reg_select == SEL_BURST |=> burst_enable == $past(iface_nibble_data[0]))
    else $error("burst enable not taken");
  a_calib_load: assert property (@(posedge aclk) disable iff (!aresetn)
    nib_we && iface_reg_select == SEL_COMMAND && iface_nibble_data == load_calib_reg_cmd |=>
    calib_load && calib_load_data == $past(data_hold_reg) &&
    calib_load_addr == $past(calib_reg_addr))
    else $error("calibration load missing");
  a_test_byte: assert property (@(posedge aclk) disable iff (!aresetn)
    read_start && iface_read_pointer == PTR_TEST |=> tx_byte_reg == TEST_BYTE && line_quiet)
    else $error("test byte not selected");
  a_quiet_pre: assert property (@(posedge aclk) disable iff (!aresetn)
    read_start |=> !dio_oe [*8])
    else $error("line driven during leading delay");
  a_direct_mode: assert property (@(posedge aclk) disable iff (!aresetn)
    restart && cfg_reg.control_word_repeat_count == REPEAT_DIRECT |=>
    digital_mode && !win_active_reg)
    else $error("direct digital mode not entered");
  a_refresh_gap: assert property (@(posedge aclk) disable iff (!aresetn)
    dac_refresh |=> !dac_refresh [*4])
    else $error("refresh pulses too close");

endmodule

//--- sim/scnd_prog_model.sv
// programmer-side model: listens on the response line and times each reply
`timescale 1ns/1ps
module scnd_prog_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] bit_period,
  input wire logic line_quiet,
  input wire logic dio_oe,
  input wire logic dio_out,
  output logic rx_done,
  output logic [39:0] rx_note
);
  logic [15:0] q_cnt;
  logic [15:0] oe_cnt;
  logic [15:0] pre_cnt;
  logic [7:0] shreg;
  ////////////////////////////////////////////////////////////////////////////
  // never drives while the device holds the line; samples mid-bit, lsb first
  always @(posedge aclk) begin
    rx_done <= 1'b0;
    if (!aresetn) begin
      q_cnt <= 16'h0000;
      oe_cnt <= 16'h0000;
      rx_note <= 40'h0;
    end else if (line_quiet) begin
      q_cnt <= q_cnt + 16'h0001;
      if (dio_oe) begin
        if (oe_cnt == 16'h0000) pre_cnt <= q_cnt;
        if (oe_cnt % bit_period == bit_period / 2) shreg <= {dio_out, shreg[7:1]};
        oe_cnt <= oe_cnt + 16'h0001;
      end
    end else if (q_cnt != 16'h0000) begin
      rx_note <= {shreg, pre_cnt, q_cnt};
      rx_done <= 1'b1;
      q_cnt <= 16'h0000;
      oe_cnt <= 16'h0000;
    end
  end
endmodule

//--- sim/test_serial_config_nibble_decoder.sv
// self-checking bench for the serial config nibble decoder
`timescale 1ns/1ps
module test_serial_config_nibble_decoder
  import scnd_pkg::*;
;
  typedef struct packed {logic [1:0] resp; logic [31:0] mask; logic [31:0] data;} scnd_note_t;
  localparam int OSC_D = 2;
  localparam logic [15:0] BP = 16'h0004;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, sel, dat, ca = 4'h0, fm = 4'h0, ptr = 4'h0;
  logic [3:0] cmd = 4'h0, tmo = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, burst = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic digital_mode, calib_load, dac_refresh, dio_out, dio_oe, line_quiet, rx_done;
  logic [3:0] calib_load_addr;
  logic [15:0] calib_load_data, hold = 16'h0;
  logic [39:0] rx_note;
  logic burst_enable;
  logic [4:0] analog_location;
  logic [3:0] analog_timeout;
  logic [10:0] flash_address;
  logic [4:0] loc = 5'h0;
  int bad_count = 0, num_checks = 0, seed = 73, t;
  scnd_note_t rq[$], rn;
  logic [1:0] bq[$];
  logic [19:0] cq[$];
  logic [39:0] xq[$];
  always #2.5 aclk = ~aclk;
  scnd_decoder #(.OSC_DIV(OSC_D)) scnd_decoder_i (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .digital_mode, .calib_load, .calib_load_addr, .calib_load_data,
    .dac_refresh, .dio_out, .dio_oe, .line_quiet, .burst_enable, .analog_location,
    .analog_timeout, .flash_address);
  scnd_prog_model scnd_prog_model_i (.aclk, .aresetn, .bit_period(BP), .line_quiet,
    .dio_oe, .dio_out, .rx_done, .rx_note);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // results are matched to the oldest note of their kind
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      rn = rq.pop_front();
      chk("rdata", rn.data, s_axi_rdata & rn.mask);
      chk("rresp", rn.resp, s_axi_rresp);
    end
    if (s_axi_bvalid && s_axi_bready) chk("bresp", bq.pop_front(), s_axi_bresp);
    if (calib_load) chk("calib load", cq.pop_front(), {calib_load_addr, calib_load_data});
    if (rx_done) chk("response", xq.pop_front(), rx_note);
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!s_axi_bvalid) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
      input logic [1:0] r = 2'b00);
    rq.push_back('{r, m, e});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!s_axi_rvalid) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic test_done();
    if (rq.size() + bq.size() + cq.size() + xq.size() != 0) bad_count++;
    if (bad_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge aclk);
    bad_count++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_STATUS, 32'h1, 32'h1);
    chk("digital mode", 1, digital_mode);
    rd(OFF_CONFIG, 32'h7f0, 32'h7ff);
    wr(OFF_BIT_PERIOD, {16'h0, BP}, 2'b00);
    wr(8'h24, 32'h0, 2'b10);
    rd(8'h30, 32'h0, 32'hffffffff, 2'b10);
    for (int i = 0; i < 48; i++) begin
      sel = i[3:0];
      dat = 4'($random(seed));
      // the last command slot always loads, so the load path is exercised
      if (sel == 4'h9 && (dat == 4'h5 || i == 41)) dat = 4'h0;
      case (sel)
        4'h0, 4'h1, 4'h2, 4'h3: hold[sel * 4 +: 4] = dat;
        4'h6: ca = dat;
        4'h7: fm = dat;
        4'h8: ptr = dat;
        4'h9: cmd = dat;
        4'ha: tmo = dat;
        4'hb: loc[3:0] = dat;
        4'hc: loc[4] = dat[0];
        4'hd: burst = dat[0];
        default: ;
      endcase
      if (sel == 4'h9 && dat == 4'h0) cq.push_back({ca, hold});
      wr(OFF_NIBBLE, {24'h0, sel, dat}, 2'b00);
      rd(OFF_HOLD, {16'h0, hold}, 32'hffff);
      rd(OFF_ADDR, {17'h0, ptr, ptr[2:0], fm, ca}, 32'h7fff);
      rd(OFF_CMD, {18'h0, burst, loc, tmo, cmd}, 32'h3fff);
      chk("pins", {burst, loc, tmo, ptr[2:0], fm, ca},
          {burst_enable, analog_location, analog_timeout, flash_address});
    end
    for (int d = 0; d < 4; d++) begin
      wr(OFF_CONFIG, 32'h7f0 | (d << 2), 2'b00);
      wr(OFF_NIBBLE, 32'h8f, 2'b00);
      t = (8 << d) * BP;
      xq.push_back({8'hca, 16'(t), 16'(2 * t + 8 * BP)});
      wr(OFF_NIBBLE, 32'h95, 2'b00);
      repeat (4) @(posedge aclk);
      while (line_quiet) @(posedge aclk);
      rd(OFF_RESP, 32'hca, 32'hff);
    end
    for (int w = 0; w < 2; w++) begin
      wr(OFF_CONFIG, w << 4, 2'b00);
      wr(OFF_SESSION, 32'h2, 2'b00);
      repeat ((w + 1) * 1000 * OSC_D - 100) @(posedge aclk);
      rd(OFF_STATUS, 32'h2, 32'h3);
      repeat (200) @(posedge aclk);
      rd(OFF_STATUS, 32'h0, 32'h3);
      chk("digital mode", 0, digital_mode);
    end
    wr(OFF_CONFIG, 32'h7f0, 2'b00);
    wr(OFF_SESSION, 32'h2, 2'b00);
    rd(OFF_STATUS, 32'h1, 32'h1);
    wr(OFF_CONFIG, 32'h210, 2'b00);
    wr(OFF_SESSION, 32'h2, 2'b00);
    wr(OFF_SESSION, 32'h1, 2'b00);
    rd(OFF_STATUS, 32'h08, 32'h39);
    wr(OFF_SESSION, 32'h1, 2'b00);
    rd(OFF_STATUS, 32'h1, 32'h1);
    chk("digital mode", 1, digital_mode);
    wr(OFF_CONFIG, 32'h7f0, 2'b00);
    for (t = 0; t < 20000 && !dac_refresh; t++) @(posedge aclk);
    @(posedge aclk);
    for (t = 1; t < 20000 && !dac_refresh; t++) @(posedge aclk);
    chk("refresh interval", 4096 * OSC_D, t);
    test_done();
  end
endmodule
